// *** rtl/lwm_exec.sv ***
// Four-phase executor for literal load, accumulator store and bank load.
// Assumes instructions come from logic on clk; other opcodes are refused.
`timescale 1ns/1ps

module lwm_exec (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic instr_valid,
	input wire logic [lwm_pkg::INSTR_W-1:0] instr,
	input wire logic ext_set_en,
	input wire logic [lwm_pkg::ADDR_W-1:0] index_base,
	output logic instr_ready,
	output logic [lwm_pkg::DATA_W-1:0] accumulator,
	output logic [lwm_pkg::DATA_W-1:0] bank_select_register,
	output logic file_we,
	output logic [lwm_pkg::ADDR_W-1:0] file_addr,
	output logic [lwm_pkg::DATA_W-1:0] file_wdata,
	output logic file_indexed,
	output logic exec_done,
	output logic instr_refused
);

	// ==========================================================
	// Reset release
	logic rst_meta_n;
	logic rst_n;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// ==========================================================
	// Decode
	function automatic lwm_pkg::lwm_op_e lwm_decode(
		input logic [lwm_pkg::INSTR_W-1:0] word
	);
		lwm_pkg::lwm_op_e op;
		op = lwm_pkg::LWM_OP_NONE;
		if (word[lwm_pkg::INSTR_W-1:lwm_pkg::OPC8_LSB] ==
				lwm_pkg::OPC_LOAD_LIT) begin
			op = lwm_pkg::LWM_OP_LOAD_LIT;
		end else if (word[lwm_pkg::INSTR_W-1:lwm_pkg::OPC8_LSB] ==
				lwm_pkg::OPC_LOAD_BANK) begin
			op = lwm_pkg::LWM_OP_LOAD_BANK;
		end else if (word[lwm_pkg::INSTR_W-1:lwm_pkg::OPC7_LSB] ==
				lwm_pkg::OPC_STORE_ACC) begin
			op = lwm_pkg::LWM_OP_STORE_ACC;
		end
		return op;
	endfunction

	// ==========================================================
	// Phase sequencer
	lwm_pkg::lwm_phase_e phase;
	lwm_pkg::lwm_phase_e next_phase;
	logic take;

	// One instruction per four clocks; the slot is taken only in Q1
	assign instr_ready = (phase == lwm_pkg::LWM_Q1);
	assign take = instr_ready && instr_valid;

	always_comb begin
		case (phase)
			lwm_pkg::LWM_Q1: begin
				next_phase = take ? lwm_pkg::LWM_Q2 : lwm_pkg::LWM_Q1;
			end
			lwm_pkg::LWM_Q2: begin
				next_phase = lwm_pkg::LWM_Q3;
			end
			lwm_pkg::LWM_Q3: begin
				next_phase = lwm_pkg::LWM_Q4;
			end
			lwm_pkg::LWM_Q4: begin
				next_phase = lwm_pkg::LWM_Q1;
			end
			default: begin
				next_phase = lwm_pkg::LWM_Q1;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= lwm_pkg::LWM_Q1;
		end else begin
			phase <= next_phase;
		end
	end

	// ==========================================================
	// Instruction hold
	lwm_pkg::lwm_op_e op;
	lwm_pkg::lwm_op_e in_op;
	logic [lwm_pkg::DATA_W-1:0] literal;
	logic access_sel;

	assign in_op = lwm_decode(instr);

	// Unsupported opcodes still take a four-clock slot but commit nothing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			op <= lwm_pkg::LWM_OP_NONE;
			literal <= lwm_pkg::ACC_RESET;
			access_sel <= 1'b0;
		end else if (take) begin
			op <= in_op;
			literal <= instr[lwm_pkg::DATA_W-1:0];
			access_sel <= instr[lwm_pkg::ACCESS_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			instr_refused <= 1'b0;
		end else begin
			instr_refused <= take && (in_op == lwm_pkg::LWM_OP_NONE);
		end
	end

	// ==========================================================
	// Address
	logic [lwm_pkg::BANK_W-1:0] bank_sel;
	logic [lwm_pkg::ADDR_W-1:0] res_addr;
	logic res_indexed;

	lwm_addr_resolve lwm_addr_resolve_i (
		.file_field(literal),
		.access_sel(access_sel),
		.bank_select_register(bank_sel),
		.ext_set_en(ext_set_en),
		.index_base(index_base),
		.file_addr(res_addr),
		.indexed(res_indexed)
	);

	// ==========================================================
	// Write phase
	logic q4_write;
	logic acc_commit;
	logic bank_commit;
	logic store_commit;

	// Every write lands at the end of Q4, so a held word commits once
	function automatic logic lwm_commit(
		input lwm_pkg::lwm_phase_e at_phase,
		input lwm_pkg::lwm_op_e held_op,
		input lwm_pkg::lwm_op_e kind
	);
		return (at_phase == lwm_pkg::LWM_Q4) && (held_op == kind);
	endfunction

	assign q4_write = (phase == lwm_pkg::LWM_Q4);
	assign acc_commit =
		lwm_commit(phase, op, lwm_pkg::LWM_OP_LOAD_LIT);
	assign bank_commit =
		lwm_commit(phase, op, lwm_pkg::LWM_OP_LOAD_BANK);
	assign store_commit =
		lwm_commit(phase, op, lwm_pkg::LWM_OP_STORE_ACC);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			accumulator <= lwm_pkg::ACC_RESET;
		end else if (acc_commit) begin
			accumulator <= literal;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bank_sel <= lwm_pkg::BANK_RESET;
		end else if (bank_commit) begin
			bank_sel <= literal[lwm_pkg::BANK_W-1:0];
		end
	end

	// Upper half is wired to zero so no literal can reach it
	assign bank_select_register = {lwm_pkg::BANK_UPPER_ZERO, bank_sel};

	// No status port exists: none of these moves touch the flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			file_we <= 1'b0;
		end else begin
			file_we <= store_commit;
		end
	end

	// Address and data stand until the next store
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			file_addr <= '0;
			file_wdata <= lwm_pkg::ACC_RESET;
			file_indexed <= 1'b0;
		end else if (store_commit) begin
			file_addr <= res_addr;
			file_wdata <= accumulator;
			file_indexed <= res_indexed;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			exec_done <= 1'b0;
		end else begin
			exec_done <= q4_write;
		end
	end

endmodule

// *** include/lwm_pkg.sv ***
// Shared constants for the literal and accumulator move executor.
// Assumes a 16-bit instruction word and a 12-bit data address space.
package lwm_pkg;

	// ==========================================================
	// Widths
	localparam int DATA_W = 8;
	localparam int INSTR_W = 16;
	localparam int ADDR_W = 12;
	localparam int BANK_W = 4;

	// ==========================================================
	// Instruction fields
	localparam int OPC8_LSB = 8;
	localparam int OPC7_LSB = 9;
	localparam int ACCESS_BIT = 8;
	localparam logic [7:0] OPC_LOAD_LIT = 8'h0e;
	localparam logic [7:0] OPC_LOAD_BANK = 8'h01;
	localparam logic [6:0] OPC_STORE_ACC = 7'h37;

	// ==========================================================
	// Address resolution
	localparam logic [7:0] INDEX_LIMIT = 8'h5f;
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;
	localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hf;

	// ==========================================================
	// Reset values
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [BANK_W-1:0] BANK_RESET = 4'h0;
	localparam logic [BANK_W-1:0] BANK_UPPER_ZERO = 4'h0;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		LWM_Q1 = 2'b00,
		LWM_Q2 = 2'b01,
		LWM_Q3 = 2'b10,
		LWM_Q4 = 2'b11
	} lwm_phase_e;

	typedef enum logic [1:0] {
		LWM_OP_NONE = 2'b00,
		LWM_OP_LOAD_LIT = 2'b01,
		LWM_OP_STORE_ACC = 2'b10,
		LWM_OP_LOAD_BANK = 2'b11
	} lwm_op_e;

endpackage

// *** rtl/lwm_addr_resolve.sv ***
// Resolves the 12-bit data address of a store from its 8-bit field.
// Assumes the bank select and index base are stable during the cycle.
`timescale 1ns/1ps

module lwm_addr_resolve (
	input wire logic [7:0] file_field,
	input wire logic access_sel,
	input wire logic [lwm_pkg::BANK_W-1:0] bank_select_register,
	input wire logic ext_set_en,
	input wire logic [lwm_pkg::ADDR_W-1:0] index_base,
	output logic [lwm_pkg::ADDR_W-1:0] file_addr,
	output logic indexed
);

	// ==========================================================
	// Bank choice
	always_comb begin
		indexed = 1'b0;
		if (access_sel) begin
			file_addr = {bank_select_register, file_field};
		end else if (ext_set_en && file_field <= lwm_pkg::INDEX_LIMIT) begin
			// Offset from the index base wraps inside the data space
			file_addr = lwm_pkg::ADDR_W'(index_base + file_field);
			indexed = 1'b1;
		end else if (file_field < lwm_pkg::ACCESS_SPLIT) begin
			file_addr = {lwm_pkg::ACCESS_LOW_BANK, file_field};
		end else begin
			file_addr = {lwm_pkg::ACCESS_HIGH_BANK, file_field};
		end
	end

endmodule

// *** verification/lwm_exec_assertions.sv ***
// Port checker of the move executor.
// Assumes no offer within two edges of reset release.
`timescale 1ns/1ps
module lwm_exec_assertions (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic instr_valid,
	input wire logic [15:0] instr,
	input wire logic ext_set_en,
	input wire logic [11:0] index_base,
	input wire logic instr_ready,
	input wire logic [7:0] accumulator,
	input wire logic [7:0] bank_select_register,
	input wire logic file_we,
	input wire logic [11:0] file_addr,
	input wire logic [7:0] file_wdata,
	input wire logic file_indexed,
	input wire logic exec_done,
	input wire logic instr_refused
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// ====
	// Taken words by kind
	wire tk = instr_ready && instr_valid;
	wire [7:0] f = instr[7:0];
	wire st = tk && instr[15:9] == 7'h37;
	wire ix = st && !instr[8] && ext_set_en && f <= 8'h5f;
	wire [11:0] ia = index_base + {4'h0, f};
	// ====
	// Properties
	chk_store_data: assert property (st |-> ##4 file_we &&
		file_wdata == accumulator) else $error("store data");
	chk_store_bank: assert property (st && instr[8] |-> ##4
		file_addr == {bank_select_register[3:0], $past(f, 4)})
		else $error("banked address");
	chk_access_fixed: assert property (st && !instr[8] && !ix |->
		##4 !file_indexed && file_addr ==
		{$past(f[7], 4) ? 4'hf : 4'h0, $past(f, 4)})
		else $error("access address");
	chk_indexed_store: assert property (ix |-> ##4 file_indexed &&
		file_addr == $past(ia, 4)) else $error("indexed address");
	chk_bank_upper: assert property (bank_select_register[7:4] == 4'h0)
		else $error("bank upper");
	chk_bank_load: assert property (tk && instr[15:8] == 8'h01 |->
		##4 bank_select_register == {4'h0, $past(instr[3:0], 4)})
		else $error("bank load");
	chk_lit_load: assert property (tk && instr[15:8] == 8'h0e |->
		##4 exec_done && accumulator == $past(f, 4))
		else $error("literal load");
	chk_no_store: assert property (tk && !st |-> ##4 !file_we)
		else $error("stray write");
	cover property (st && instr[8]);
	cover property (ix);
	cover property (instr_refused);
endmodule

// *** verification/lwm_exec_tb.sv ***
// Bench of the move executor, driving every input itself.
// Assumes the executor and its checker are compiled beside it.
`timescale 1ns/1ps
module lwm_exec_tb;
	logic clk = 0, arst_n = 0, instr_valid = 0, ext_set_en = 0;
	logic [15:0] instr = 16'h0000;
	// Base near the top, so the indexed sum wraps
	logic [11:0] index_base = 12'hff0;
	logic instr_ready, file_we, file_indexed, exec_done, instr_refused;
	logic [7:0] accumulator, bank_select_register, file_wdata;
	logic [11:0] file_addr;
	logic we, rf;
	int error_cnt = 0, n_compared = 0;
	lwm_exec lwm_exec_i (.*);
	always #12.5 clk = ~clk;
	// ====
	// Shared tasks
	task give_verdict;
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Called at a falling edge with ready high; returns in the done cycle
	task exec(input logic [15:0] w);
		int i;
		instr = w;
		instr_valid = 1;
		rf = 0;
		@(negedge clk) instr_valid = 0;
		chk(instr_ready, 16'h0000);
		for (i = 0; i < 8 && exec_done !== 1'b1; i++) begin
			rf |= instr_refused;
			@(negedge clk);
		end
		if (exec_done !== 1'b1) begin
			error_cnt++;
			$display("FAIL t=%0t got %h exp %h", $time, exec_done, 1'b1);
			give_verdict;
		end
		we = file_we;
	endtask
	// ====
	// Scenarios
	task t_moves;
		exec(16'h0e5a);
		chk(accumulator, 16'h005a);
		chk(we, 16'h0000);
		exec(16'h01f5);
		chk(bank_select_register, 16'h0005);
		exec(16'h6f12);
		chk({we, file_addr}, 16'h1512);
		chk(file_wdata, 16'h005a);
		exec(16'h0ea5);
		exec(16'h6f00);
		chk(file_wdata, 16'h00a5);
		chk(file_addr, 16'h0500);
	endtask
	task t_access;
		exec(16'h6e12);
		chk({file_indexed, file_addr}, 16'h0012);
		exec(16'h6e90);
		chk(file_addr, 16'h0f90);
		ext_set_en = 1;
		exec(16'h6e5f);
		chk({file_indexed, file_addr}, 16'h104f);
		exec(16'h6e60);
		chk({file_indexed, file_addr}, 16'h0060);
		exec(16'h6fff);
		chk({we, file_addr}, 16'h15ff);
	endtask
	task t_refuse;
		exec(16'hffff);
		chk({rf, we}, 16'h0002);
		chk(accumulator, 16'h00a5);
	endtask
	initial begin
		repeat (3) @(negedge clk);
		arst_n = 1;
		repeat (4) @(negedge clk);
		t_moves();
		t_access();
		t_refuse();
		give_verdict;
	end
endmodule
bind lwm_exec lwm_exec_assertions lwm_exec_assertions_i (.*);
